/* include/itmr_defs.svh */
`ifndef ITMR_DEFS_SVH
`define ITMR_DEFS_SVH

// control word layout
`define ITMR_CTRL_WIDTH      16
`define ITMR_BIT_SRC_SEL     1
`define ITMR_BIT_SYNC_SEL    2
`define ITMR_BIT_GATE_EN     6
`define ITMR_BIT_PRESC_LO    4
`define ITMR_BIT_PRESC_HI    5
`define ITMR_BIT_TIMER_ON    15

// prescaler ratio codes and terminal counts
`define ITMR_PRESC_W         8
`define ITMR_PRESC_DIV1      2'h0
`define ITMR_PRESC_DIV8      2'h1
`define ITMR_PRESC_DIV64     2'h2
`define ITMR_PRESC_DIV256    2'h3
`define ITMR_LIM_DIV1        8'h00
`define ITMR_LIM_DIV8        8'h07
`define ITMR_LIM_DIV64       8'h3f
`define ITMR_LIM_DIV256      8'hff

// reset values and synchroniser width
`define ITMR_PRESC_RST       8'h00
`define ITMR_SYNC_WIDTH      2
`define ITMR_SYNC_PIN        0
`define ITMR_SYNC_GATE       1

`endif

/* include/itmr_pkg.sv */
package itmr_pkg;

    // operating mode decoded from the control word
    typedef enum logic [1:0] {
        ITMR_TIMER     = 2'b00,
        ITMR_GATED     = 2'b01,
        ITMR_SYNC_CNT  = 2'b10,
        ITMR_ASYNC_CNT = 2'b11
    } itmr_mode_e;

    typedef logic [1:0] itmr_presc_t;

endpackage : itmr_pkg

/* logic/itmr_sync.sv */
`timescale 1ns/1ps

// two-flop synchroniser for pin inputs
module itmr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage2_next;

    // refuse an empty synchroniser
    if (WIDTH < 1) begin : g_bad_width
        $error("itmr_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_comb begin
        stage1_next = async_in;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync_out = stage2_reg;

endmodule : itmr_sync

/* logic/itmr_top.sv */
`timescale 1ns/1ps
`include "itmr_defs.svh"

module itmr_top
    import itmr_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic [`ITMR_CTRL_WIDTH-1:0] timer_control_reg,
    input  wire logic [CNT_WIDTH-1:0]        period_value,
    input  wire logic                        ext_count_clock_pin,
    input  wire logic                        gate_pin,
    input  wire logic                        flag_clear,
    output logic      [CNT_WIDTH-1:0]        count_value,
    output logic                             event_flag,
    output logic                             event_pulse
);

    // refuse counter widths the wrap logic cannot serve
    if (CNT_WIDTH < 2) begin : g_bad_width
        $error("itmr_top: CNT_WIDTH must be at least 2");
    end

    // decode of the mode from the control word
    function automatic itmr_mode_e mode_of(input logic [`ITMR_CTRL_WIDTH-1:0] ctrl);
        itmr_mode_e m;
        m = ITMR_TIMER;
        if (ctrl[`ITMR_BIT_SRC_SEL]) begin
            m = ctrl[`ITMR_BIT_SYNC_SEL] ? ITMR_SYNC_CNT : ITMR_ASYNC_CNT;
        end else begin
            m = ctrl[`ITMR_BIT_GATE_EN] ? ITMR_GATED : ITMR_TIMER;
        end
        return m;
    endfunction : mode_of

    // terminal count of the prescaler for a ratio code
    function automatic logic [`ITMR_PRESC_W-1:0] presc_limit(input itmr_presc_t sel);
        logic [`ITMR_PRESC_W-1:0] lim;
        lim = `ITMR_LIM_DIV1;
        unique case (sel)
            `ITMR_PRESC_DIV1:   lim = `ITMR_LIM_DIV1;
            `ITMR_PRESC_DIV8:   lim = `ITMR_LIM_DIV8;
            `ITMR_PRESC_DIV64:  lim = `ITMR_LIM_DIV64;
            `ITMR_PRESC_DIV256: lim = `ITMR_LIM_DIV256;
        endcase
        return lim;
    endfunction : presc_limit

    logic [`ITMR_SYNC_WIDTH-1:0] pins_sync;
    logic                        pin_sync;
    logic                        gate_sync;
    itmr_mode_e                  mode;
    logic                        timer_on;
    itmr_presc_t                 presc_sel;
    logic                        ext_edge;
    logic                        src_tick;
    logic                        presc_out;
    logic                        cnt_tick;
    logic                        period_hit;

    logic                        pin_prev_reg;
    logic                        pin_prev_next;
    logic [`ITMR_PRESC_W-1:0]    presc_reg;
    logic [`ITMR_PRESC_W-1:0]    presc_next;
    logic                        align_reg;
    logic                        align_next;
    logic [CNT_WIDTH-1:0]        count_reg;
    logic [CNT_WIDTH-1:0]        count_next;
    logic                        flag_reg;
    logic                        flag_next;
    logic                        pulse_reg;
    logic                        pulse_next;

    // pin and gate pass two flops first
    itmr_sync #(
        .WIDTH (`ITMR_SYNC_WIDTH)
    ) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .async_in ({gate_pin, ext_count_clock_pin}),
        .sync_out (pins_sync)
    );

    assign pin_sync  = pins_sync[`ITMR_SYNC_PIN];
    assign gate_sync = pins_sync[`ITMR_SYNC_GATE];
    assign mode      = mode_of(timer_control_reg);
    assign timer_on  = timer_control_reg[`ITMR_BIT_TIMER_ON];
    assign presc_sel = timer_control_reg[`ITMR_BIT_PRESC_HI:`ITMR_BIT_PRESC_LO];

    // source tick selection
    always_comb begin
        ext_edge = pin_sync & ~pin_prev_reg;
        src_tick = 1'b0;
        unique case (mode)
            ITMR_TIMER:     src_tick = 1'b1;
            ITMR_GATED:     src_tick = gate_sync;
            ITMR_SYNC_CNT:  src_tick = ext_edge;
            ITMR_ASYNC_CNT: src_tick = ext_edge;
        endcase
        src_tick  = src_tick & timer_on;
        // at or past the limit, so a ratio cut on the fly cannot run to wrap
        presc_out = src_tick && (presc_reg >= presc_limit(presc_sel));
    end

    // prescaler, alignment stage and counter tick
    always_comb begin
        pin_prev_next = pin_sync;
        presc_next    = presc_reg;
        if (!timer_on) begin
            presc_next = `ITMR_PRESC_RST;
        end else if (presc_out) begin
            presc_next = `ITMR_PRESC_RST;
        end else if (src_tick) begin
            presc_next = presc_reg + 1'b1;
        end
        align_next = presc_out;
        if (mode == ITMR_SYNC_CNT) begin
            cnt_tick = align_reg;
        end else begin
            cnt_tick = presc_out;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_prev_reg <= 1'b0;
            presc_reg    <= `ITMR_PRESC_RST;
            align_reg    <= 1'b0;
        end else begin
            pin_prev_reg <= pin_prev_next;
            presc_reg    <= presc_next;
            align_reg    <= align_next;
        end
    end

    // counter, period match and event flag
    always_comb begin
        period_hit = cnt_tick && (count_reg == period_value);
        count_next = count_reg;
        if (period_hit) begin
            count_next = '0;
        end else if (cnt_tick) begin
            count_next = count_reg + 1'b1;
        end
        flag_next  = period_hit | (flag_reg & ~flag_clear); // set wins
        pulse_next = period_hit;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            flag_reg  <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            flag_reg  <= flag_next;
            pulse_reg <= pulse_next;
        end
    end

    assign count_value = count_reg;
    assign event_flag  = flag_reg;
    assign event_pulse = pulse_reg;

    // checks on the counting path
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_sync_presc;
        (mode == ITMR_SYNC_CNT) && presc_out;
    endsequence

    sequence s_sync_held;
        mode == ITMR_SYNC_CNT;
    endsequence

    a_count_incr: assert property (
        cnt_tick && !period_hit |=> count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not advance by one");

    a_count_hold: assert property (
        !cnt_tick |=> count_reg == $past(count_reg))
        else $error("counter moved without a tick");

    a_int_clock: assert property (
        timer_on && mode == ITMR_TIMER && presc_sel == `ITMR_PRESC_DIV1 |-> cnt_tick)
        else $error("timer mode missed an instruction clock tick");

    a_ext_only: assert property (
        (mode == ITMR_SYNC_CNT || mode == ITMR_ASYNC_CNT) && !ext_edge |-> !src_tick)
        else $error("counter mode ticked without a pin edge");

    a_src_decode: assert property (
        timer_control_reg[`ITMR_BIT_SRC_SEL] |-> mode == ITMR_SYNC_CNT || mode == ITMR_ASYNC_CNT)
        else $error("source select not honoured");

    a_sync_decode: assert property (
        timer_control_reg[`ITMR_BIT_SRC_SEL] && timer_control_reg[`ITMR_BIT_SYNC_SEL]
        |-> mode == ITMR_SYNC_CNT)
        else $error("sync select not honoured");

    a_gate_decode: assert property (
        !timer_control_reg[`ITMR_BIT_SRC_SEL] && timer_control_reg[`ITMR_BIT_GATE_EN]
        |-> mode == ITMR_GATED)
        else $error("gate enable not honoured");

    a_sync_after: assert property (
        s_sync_presc ##1 s_sync_held |-> cnt_tick)
        else $error("aligned tick missing one cycle after prescaler");

    a_async_direct: assert property (
        mode == ITMR_ASYNC_CNT && presc_out |-> cnt_tick)
        else $error("async mode did not pass prescaler output directly");

    a_gate_low: assert property (
        mode == ITMR_GATED && !gate_sync |-> !src_tick)
        else $error("gated timer counted with gate low");

    a_period_wrap: assert property (
        period_hit |=> count_reg == '0 && flag_reg && pulse_reg)
        else $error("period match did not wrap and flag");

    a_flag_sticky: assert property (
        flag_reg && !flag_clear |=> flag_reg)
        else $error("event flag dropped without a clear");

endmodule : itmr_top

/* testbench/itmr_ext_src.sv */
`timescale 1ns/1ps

// count pin and gate source, driven off the falling edge
module itmr_ext_src (
    input  wire logic clock,
    output logic      ext_count_clock_pin,
    output logic      gate_pin
);
    // idle levels: count pin stands low outside bursts
    initial begin
        ext_count_clock_pin = 1'b0;
        gate_pin            = 1'b0;
    end

    // n pulses, each level held 3 clocks so two flops see it
    task automatic send_pulses(input int n);
        repeat (n) begin
            @(negedge clock) ext_count_clock_pin = 1'b1;
            repeat (3) @(negedge clock);
            ext_count_clock_pin = 1'b0;
            repeat (2) @(negedge clock);
        end
    endtask : send_pulses

    // count pin level change on a falling edge
    task automatic set_pin(input logic level);
        @(negedge clock) ext_count_clock_pin = level;
    endtask : set_pin

    // gate level change on a falling edge
    task automatic set_gate(input logic level);
        @(negedge clock) gate_pin = level;
    endtask : set_gate
endmodule : itmr_ext_src

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "itmr_defs.svh"

module testbench
    import itmr_pkg::*;
;
    logic        clock, rstn, ext_pin, gate, flag_clear, event_flag, event_pulse;
    logic [15:0] ctrl, period, count;
    int          n_mismatch, n_compared, cycles;

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    itmr_top #(.CNT_WIDTH(16)) dut_u (
        .clock(clock), .rstn(rstn), .timer_control_reg(ctrl), .period_value(period),
        .ext_count_clock_pin(ext_pin), .gate_pin(gate), .flag_clear(flag_clear),
        .count_value(count), .event_flag(event_flag), .event_pulse(event_pulse));

    itmr_ext_src src_u (.clock(clock), .ext_count_clock_pin(ext_pin), .gate_pin(gate));

    // verdict and end of run
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk_val(input logic [15:0] act, input logic [15:0] exp);
        n_compared++;
        if (act !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic act, input logic exp);
        n_compared++;
        if (act !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : chk_bit

    // control word: timer on plus chosen fields
    function automatic logic [15:0] mk_ctrl(input logic src, input logic sync,
                                            input logic gen, input itmr_presc_t ps);
        logic [15:0] c;
        c = 16'h0000;
        c[`ITMR_BIT_TIMER_ON] = 1'b1;
        c[`ITMR_BIT_SRC_SEL] = src;
        c[`ITMR_BIT_SYNC_SEL] = sync;
        c[`ITMR_BIT_GATE_EN] = gen;
        c[`ITMR_BIT_PRESC_HI:`ITMR_BIT_PRESC_LO] = ps;
        return c;
    endfunction : mk_ctrl

    task automatic do_reset;
        @(negedge clock);
        rstn = 1'b0;
        ctrl = 16'h0000;
        flag_clear = 1'b0;
        period = 16'hffff;
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        repeat (2) @(negedge clock);
    endtask : do_reset

    task automatic wait_count(input logic [15:0] v);
        int i;
        for (i = 0; i < 300 && count !== v; i++) @(negedge clock);
        chk_val(count, v);
    endtask : wait_count

    // plain timer, period 2, sync and gate ignored, flag clear
    task automatic t_timer;
        logic [15:0] e;
        do_reset();
        period = 16'h0002;
        ctrl = mk_ctrl(1'b0, 1'b1, 1'b0, `ITMR_PRESC_DIV1);
        wait_count(16'h0001);
        for (int i = 0; i < 9; i++) begin
            @(negedge clock);
            e = (i % 3 == 0) ? 16'h0002 : (i % 3 == 1) ? 16'h0000 : 16'h0001;
            chk_val(count, e);
            chk_bit(event_pulse, e == 16'h0000);
        end
        chk_bit(event_flag, 1'b1);
        ctrl[`ITMR_BIT_TIMER_ON] = 1'b0;
        flag_clear = 1'b1;
        repeat (3) @(negedge clock);
        flag_clear = 1'b0;
        chk_bit(event_flag, 1'b0);
        repeat (10) @(negedge clock);
        chk_val(count, 16'h0001); // frozen at its last value
        $display("test timer done");
    endtask : t_timer

    // gated timer: frozen while gate low; gate fall seen after two flops
    task automatic t_gated;
        do_reset();
        src_u.set_gate(1'b0);
        ctrl = mk_ctrl(1'b0, 1'b0, 1'b1, `ITMR_PRESC_DIV1);
        repeat (10) @(negedge clock);
        chk_val(count, 16'h0000);
        src_u.set_gate(1'b1);
        wait_count(16'h0004);
        src_u.set_gate(1'b0);
        repeat (5) @(negedge clock);
        chk_val(count, 16'h0007);
        repeat (10) @(negedge clock);
        chk_val(count, 16'h0007);
        $display("test gated done");
    endtask : t_gated

    // clear and period match in one cycle: the set wins
    task automatic t_set_wins;
        do_reset();
        period = 16'h0001;
        ctrl = mk_ctrl(1'b0, 1'b0, 1'b0, `ITMR_PRESC_DIV1);
        @(negedge clock);
        flag_clear = 1'b1;
        @(negedge clock);
        chk_bit(event_flag, 1'b1);
        chk_bit(event_pulse, 1'b1);
        @(negedge clock);
        chk_bit(event_flag, 1'b0);
        flag_clear = 1'b0;
        $display("test set wins done");
    endtask : t_set_wins

    // timer mode at a long ratio: end points of the first two ticks
    task automatic t_presc(input itmr_presc_t ps, input int ratio);
        do_reset();
        ctrl = mk_ctrl(1'b0, 1'b0, 1'b0, ps);
        repeat (2 * ratio - 1) @(negedge clock);
        chk_val(count, 16'h0001);
        @(negedge clock);
        chk_val(count, 16'h0002);
        $display("test prescale %0d done", ratio);
    endtask : t_presc

    // one pin edge: sync mode lags async by the alignment stage
    task automatic t_latency(input logic sync);
        do_reset();
        ctrl = mk_ctrl(1'b1, sync, 1'b0, `ITMR_PRESC_DIV1);
        src_u.set_pin(1'b1);
        repeat (3) @(negedge clock);
        chk_val(count, sync ? 16'h0000 : 16'h0001);
        @(negedge clock);
        chk_val(count, 16'h0001);
        src_u.set_pin(1'b0);
        $display("test latency sync=%0d done", sync);
    endtask : t_latency

    // pin counting; gate bit set and gate low, both ignored here
    task automatic t_pins(input logic sync, input itmr_presc_t ps, input int n,
                          input logic [15:0] exp, input logic on);
        do_reset();
        ctrl = mk_ctrl(1'b1, sync, 1'b1, ps);
        ctrl[`ITMR_BIT_TIMER_ON] = on;
        src_u.send_pulses(n);
        repeat (8) @(negedge clock);
        chk_val(count, exp);
        $display("test pins sync=%0d done", sync);
    endtask : t_pins

    // main sequence
    initial begin
        rstn = 1'b0;
        ctrl = 16'h0000;
        period = 16'hffff;
        flag_clear = 1'b0;
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        t_timer();
        t_gated();
        t_set_wins();
        t_presc(`ITMR_PRESC_DIV64, 64);
        t_presc(`ITMR_PRESC_DIV256, 256);
        t_latency(1'b0);
        t_latency(1'b1);
        t_pins(1'b0, `ITMR_PRESC_DIV1, 5, 16'h0005, 1'b1);
        t_pins(1'b1, `ITMR_PRESC_DIV1, 3, 16'h0003, 1'b1);
        t_pins(1'b1, `ITMR_PRESC_DIV8, 16, 16'h0002, 1'b1);
        t_pins(1'b0, `ITMR_PRESC_DIV1, 4, 16'h0000, 1'b0);
        complete_run();
    end
endmodule : testbench
